/* inc/pacer_pkg.sv */
// Shared constants and carrier types for the pacer and trigger block
package pacer_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SYS_CLK_MHZ = 100;
    localparam int TIMEBASE_MHZ = 10;
    localparam int TIMEBASE_DIV = SYS_CLK_MHZ / TIMEBASE_MHZ;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] DIV_RST = 16'h0000;
    localparam int SYNC_STAGES = 2;

    // ************************************************************
    // Counter 0 modes
    // ************************************************************
    typedef enum logic [0:0] {
        EV_COUNT = 1'b0,
        EV_PULSE = 1'b1
    } ev_mode_t;

    // Counter load values presented by the parent logic
    typedef struct packed {
        logic [CNT_W-1:0] ev_reload;
        logic [CNT_W-1:0] pace_lo_reload;
        logic [CNT_W-1:0] pace_hi_reload;
    } cnt_cfg_t;

    // Trigger outputs toward the conversion update logic
    typedef struct packed {
        logic pacer_fire;
        logic outside_fire;
        logic conv_start;
    } trig_t;
endpackage

/* core/pacer_and_external_trigger.sv */
// Three-counter pacer with gated external trigger for conversion start
// How it works
// R1: Three 16-bit counters on 10 MHz timebase
// R2: Counter 0 counts events or emits pulses
// R3: Counters 1 and 2 chained as 32-bit timer
// R4: Pacer rising edge starts one conversion
// R5: Pacer pulse exported as sync output
// R6: External trigger enabled only while gate high
// R7: Enabled outside edges each start one conversion
// R8: Gate low makes outside edges ignored
// R9: Inputs synchronised; edges become single-cycle pulses
module pacer_and_external_trigger #(
    parameter int CNT_W = pacer_pkg::CNT_W
) (
    input wire logic sys_clk_in, // 100 MHz clock
    input wire logic rst_b_in, // Async reset, active low
    input wire pacer_pkg::cnt_cfg_t cfg_in, // Counter reload values
    input wire logic pace_run_in, // Pacer runs while high
    input wire logic ev_run_in, // Counter 0 runs while high
    input wire pacer_pkg::ev_mode_t ev_mode_in, // Counter 0 mode
    input wire logic ev_chan_in, // Counter 0 event input
    input wire logic outside_trigger_enable_in, // Trigger gate
    input wire logic outside_trigger_enable_alt_in, // Gate, second name
    input wire logic outside_trigger_edge_in, // External trigger clock
    output logic [CNT_W-1:0] ev_count_out, // Counter 0 value
    output logic ev_pulse_out, // Counter 0 output
    output logic pacer_sync_out, // Pacer output for other gear
    output pacer_pkg::trig_t trig_out // One-cycle trigger pulses
);
    // ************************************************************
    // Timebase divider
    // ************************************************************
    logic [7:0] div_ff;
    logic tick;

    assign tick = (div_ff == 8'(pacer_pkg::TIMEBASE_DIV - 1));

    // Fixed divide: the timebase is always one tenth of the system clock
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_ff <= 8'(pacer_pkg::DIV_RST);
        end else if (tick) begin
            div_ff <= 8'h00; // R1
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [2:0] raw;
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] sync3_ff;

    // Either name of the gate enables; both are the same pin in use
    assign raw = {ev_chan_in, outside_trigger_edge_in,
                  outside_trigger_enable_in | outside_trigger_enable_alt_in};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    sync1_ff[gi] <= 1'b0;
                end else begin
                    sync1_ff[gi] <= raw[gi]; // R9
                end
            end

            // Only the second stage reads the first; the third keeps edges
            always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    sync2_ff[gi] <= 1'b0;
                    sync3_ff[gi] <= 1'b0;
                end else begin
                    sync2_ff[gi] <= sync1_ff[gi];
                    sync3_ff[gi] <= sync2_ff[gi];
                end
            end
        end
    endgenerate

    logic gate_on;
    logic outside_rise;
    logic ev_rise;

    assign gate_on = sync2_ff[0]; // R6
    assign outside_rise = sync2_ff[1] & ~sync3_ff[1]; // R9
    assign ev_rise = sync2_ff[2] & ~sync3_ff[2];

    // ************************************************************
    // Counter 0: event counter or pulse generator
    // ************************************************************
    logic [CNT_W-1:0] ev_ff;
    logic ev_pulse_ff;

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ev_ff <= CNT_W'(pacer_pkg::CNT_RST);
        end else if (!ev_run_in) begin
            ev_ff <= cfg_in.ev_reload;
        end else if (ev_mode_in == pacer_pkg::EV_COUNT) begin
            if (ev_rise) begin
                ev_ff <= ev_ff + CNT_W'(1); // R2
            end
        end else if (tick) begin
            if (ev_ff == '0) begin
                ev_ff <= cfg_in.ev_reload; // R2
            end else begin
                ev_ff <= ev_ff - CNT_W'(1);
            end
        end
    end

    // Pulse mode: one timebase period high on each wrap
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ev_pulse_ff <= 1'b0;
        end else if (!ev_run_in || ev_mode_in == pacer_pkg::EV_COUNT) begin
            ev_pulse_ff <= 1'b0;
        end else if (tick) begin
            ev_pulse_ff <= (ev_ff == '0); // R2
        end
    end

    assign ev_count_out = ev_ff;
    assign ev_pulse_out = ev_pulse_ff;

    // ************************************************************
    // Counters 1 and 2: cascaded pacer
    // ************************************************************
    logic [CNT_W-1:0] lo_ff;
    logic [CNT_W-1:0] hi_ff;
    logic pacer_ff;
    logic pacer_prev_ff;
    logic lo_wrap;

    assign lo_wrap = tick & (lo_ff == '0);

    // Low counter divides the timebase; its wrap clocks the high one
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lo_ff <= CNT_W'(pacer_pkg::CNT_RST);
        end else if (!pace_run_in) begin
            lo_ff <= cfg_in.pace_lo_reload;
        end else if (tick) begin
            if (lo_ff == '0) begin
                lo_ff <= cfg_in.pace_lo_reload; // R1
            end else begin
                lo_ff <= lo_ff - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hi_ff <= CNT_W'(pacer_pkg::CNT_RST);
            pacer_ff <= 1'b0;
        end else if (!pace_run_in) begin
            hi_ff <= cfg_in.pace_hi_reload;
            pacer_ff <= 1'b0;
        end else if (lo_wrap) begin
            if (hi_ff == '0) begin
                hi_ff <= cfg_in.pace_hi_reload; // R3
                pacer_ff <= 1'b1;
            end else begin
                hi_ff <= hi_ff - CNT_W'(1); // R3
                pacer_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pacer_prev_ff <= 1'b0;
        end else begin
            pacer_prev_ff <= pacer_ff;
        end
    end

    assign pacer_sync_out = pacer_ff; // R5

    // ************************************************************
    // Trigger pulses
    // ************************************************************
    logic pacer_fire_ff;
    logic outside_fire_ff;
    logic conv_start_ff;
    logic pace_edge;
    logic outside_edge;

    assign pace_edge = pacer_ff & ~pacer_prev_ff; // R4
    // Gate low drops every outside edge; none are held for later
    assign outside_edge = outside_rise & gate_on; // R7 R8

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pacer_fire_ff <= 1'b0;
        end else begin
            pacer_fire_ff <= pace_edge; // R4
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            outside_fire_ff <= 1'b0;
        end else begin
            outside_fire_ff <= outside_edge; // R7
        end
    end

    // Coincident pacer and outside edges merge into a single start
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            conv_start_ff <= 1'b0;
        end else begin
            conv_start_ff <= pace_edge | outside_edge; // R4 R7
        end
    end

    // Field order follows the carrier: pacer, outside, start
    assign trig_out = {pacer_fire_ff, outside_fire_ff, conv_start_ff};
endmodule

/* tb/pacer_chk.sv */
// Assertion checker for the pacer and trigger block
module pacer_chk #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire pacer_pkg::cnt_cfg_t cfg_in,
    input wire logic pace_run_in,
    input wire logic ev_run_in,
    input wire logic outside_trigger_enable_in,
    input wire logic outside_trigger_enable_alt_in,
    input wire logic outside_trigger_edge_in,
    input wire logic [CNT_W-1:0] ev_count_out,
    input wire logic ev_pulse_out,
    input wire logic pacer_sync_out,
    input wire pacer_pkg::trig_t trig_out
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    wire gate = outside_trigger_enable_in | outside_trigger_enable_alt_in;
    a_pace_fire: assert property (
        $rose(pacer_sync_out) |=> trig_out.pacer_fire)
        else $error("pacer fire missing");
    a_pace_cause: assert property (
        trig_out.pacer_fire |-> $past(pacer_sync_out)
            && !$past(pacer_sync_out, 2))
        else $error("pacer fire without rise");
    a_conv_merge: assert property (
        trig_out.conv_start == (trig_out.pacer_fire | trig_out.outside_fire))
        else $error("conv start wrong");
    a_out_single: assert property (
        trig_out.outside_fire |=> !trig_out.outside_fire)
        else $error("outside fire too long");
    a_gate_low: assert property (
        !gate [*6] |=> !trig_out.outside_fire)
        else $error("fire with gate low");
    a_edge_fire: assert property (
        ($rose(outside_trigger_edge_in) && gate && $past(gate, 3))
            ##1 gate [*2] |-> ##[0:2] trig_out.outside_fire)
        else $error("outside fire missing");
    a_pace_idle: assert property (
        !pace_run_in [*3] |-> !pacer_sync_out)
        else $error("pacer runs while stopped");
    a_ev_hold: assert property (
        !ev_run_in [*3] |-> ev_count_out == cfg_in.ev_reload)
        else $error("counter not held");
    cover property (trig_out.outside_fire);
    cover property (trig_out.pacer_fire);
    cover property (ev_pulse_out);
endmodule

/* tb/trig_src.sv */
// Model of the outside trigger source and conversion counter
module trig_src (
    input wire logic clk_in, // System clock
    input wire logic go_in, // Request one edge
    input wire logic [2:0] len_in, // Extra high and low cycles
    input wire pacer_pkg::trig_t trig_in, // Trigger pulses
    output logic edge_out = 1'b0, // Outside trigger clock
    output int conv_count_out = 0 // Conversions started
);
    timeunit 1ns;
    timeprecision 1ns;
    // High and low each last two cycles at least so no edge is lost
    always @(posedge clk_in) begin
        if (go_in) begin
            @(negedge clk_in);
            edge_out <= 1'b1;
            repeat (len_in + 2) @(negedge clk_in);
            edge_out <= 1'b0;
            repeat (len_in + 2) @(negedge clk_in);
        end
    end
    always @(negedge clk_in) begin
        if (trig_in.conv_start === 1'b1) conv_count_out <= conv_count_out + 1;
    end
endmodule

/* tb/tb_pacer_and_external_trigger.sv */
// Self-checking bench for the pacer and trigger block
module tb_pacer_and_external_trigger;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b, pace_run, ev_run, ev_chan, gate, gate_alt, go;
    logic ev_pulse, sync, trig_edge;
    logic [2:0] len;
    logic [15:0] ev_count;
    pacer_pkg::cnt_cfg_t cfg;
    pacer_pkg::ev_mode_t mode;
    pacer_pkg::trig_t trig;
    int conv_count, cyc = 0, last_pace = 0, fail_count = 0;
    int samples_checked = 0, seed, ev_rises = 0;
    logic ev_prev = 1'b0;
    int oq[$];
    int pq[$];
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    pacer_and_external_trigger dut_u (.sys_clk_in(clk), .rst_b_in(rst_b),
        .cfg_in(cfg), .pace_run_in(pace_run), .ev_run_in(ev_run),
        .ev_mode_in(mode), .ev_chan_in(ev_chan),
        .outside_trigger_enable_in(gate),
        .outside_trigger_enable_alt_in(gate_alt),
        .outside_trigger_edge_in(trig_edge), .ev_count_out(ev_count),
        .ev_pulse_out(ev_pulse), .pacer_sync_out(sync), .trig_out(trig));
    trig_src src_u (.clk_in(clk), .go_in(go), .len_in(len), .trig_in(trig),
        .edge_out(trig_edge), .conv_count_out(conv_count));
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s exp %0h got %0h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic send_edge(logic en);
        len = 3'($random(seed));
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        if (en) oq.push_back(cyc);
        repeat (2 * len + 6) @(negedge clk);
    endtask
    always @(negedge clk) begin
        if (ev_pulse === 1'b1 && ev_prev !== 1'b1) ev_rises++;
        ev_prev = ev_pulse;
        if (trig.outside_fire === 1'b1) begin
            if (oq.size() == 0) check("stray_fire", 0, 1);
            else check("fire_lat", 1, (cyc - oq.pop_front()) inside {[3:5]});
        end
        if (trig.pacer_fire === 1'b1) begin
            if (last_pace > 0 && pq.size() > 0) check("pace_gap", pq.pop_front(), cyc - last_pace);
            last_pace = cyc;
        end
    end
    initial begin
        seed = 32'ha938;
        {rst_b, pace_run, ev_run, ev_chan, gate, gate_alt, go} = '0;
        len = 3'h0;
        mode = pacer_pkg::EV_COUNT;
        cfg = {16'h0005, 16'h0001, 16'h0002};
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) send_edge(1'b0);
        gate = 1'b1;
        repeat (6) @(negedge clk);
        repeat (6) send_edge(1'b1);
        gate = 1'b0;
        gate_alt = 1'b1;
        repeat (6) @(negedge clk);
        repeat (4) send_edge(1'b1);
        gate_alt = 1'b0;
        repeat (8) @(negedge clk);
        repeat (2) send_edge(1'b0);
        check("conv_count", 10, conv_count);
        ev_run = 1'b1;
        repeat (7) begin
            ev_chan = 1'b1;
            repeat (3) @(negedge clk);
            ev_chan = 1'b0;
            repeat (3) @(negedge clk);
        end
        repeat (4) @(negedge clk);
        check("ev_count", 16'h000c, ev_count);
        mode = pacer_pkg::EV_PULSE;
        repeat (150) @(negedge clk);
        check("ev_pulses", 1, ev_rises);
        ev_run = 1'b0;
        pace_run = 1'b1;
        repeat (3) pq.push_back(60);
        repeat (300) @(negedge clk);
        pace_run = 1'b0;
        repeat (20) @(negedge clk);
        check("pace_left", 0, pq.size());
        end_sim();
    end
endmodule
bind pacer_and_external_trigger pacer_chk #(.CNT_W(CNT_W)) chk_u (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .cfg_in(cfg_in),
    .pace_run_in(pace_run_in), .ev_run_in(ev_run_in),
    .outside_trigger_enable_in(outside_trigger_enable_in),
    .outside_trigger_enable_alt_in(outside_trigger_enable_alt_in),
    .outside_trigger_edge_in(outside_trigger_edge_in),
    .ev_count_out(ev_count_out), .ev_pulse_out(ev_pulse_out),
    .pacer_sync_out(pacer_sync_out), .trig_out(trig_out));
